// file: design/crrg_top.sv
// clock divider, ready sequencing and reset front end
`timescale 1ns/1ps
`default_nettype none
`include "crrg_params.svh"
module crrg_top (
  // oscillator clock and power-on reset
  input wire logic clock,
  input wire logic reset_n,
  // external reset and ready pins
  input wire logic initialise_in_low,
  input wire logic async_ready_in,
  input wire logic sync_ready_in,
  // core bus request
  input wire logic bus_request,
  input wire logic [19:0] core_addr,
  // processor clock and reset out
  output logic processor_clock_out,
  output logic reset_out,
  // core status
  output logic core_run,
  output crrg_pkg::crrg_init_regs_t init_regs,
  // bus sequence
  output crrg_pkg::crrg_bus_state_t bus_state,
  output logic [19:0] bus_addr,
  output logic bus_cycle_done,
  output logic [3:0] wait_count
);
  crrg_pkg::crrg_top_state_t st_r;
  crrg_pkg::crrg_top_state_t st_nxt;
  logic mid_en;
  logic end_en;
  logic sample_state;
  logic cycle_start;
  logic ready_ok;

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic [2:0] lim);
    sat_inc = (v >= lim) ? lim : 3'(v + `CRRG_CNT_ONE);
  endfunction

  function automatic logic in_sample_state(input crrg_pkg::crrg_bus_state_t s);
    in_sample_state = (s == crrg_pkg::second_bus_state) ||
                      (s == crrg_pkg::third_bus_state) ||
                      (s == crrg_pkg::wait_state);
  endfunction

  function automatic crrg_pkg::crrg_init_regs_t reset_regs();
    reset_regs.status_word = `CRRG_RST_STATUS_WORD;
    reset_regs.instr_ptr = `CRRG_RST_ZERO_WORD;
    reset_regs.code_seg = `CRRG_RST_CODE_SEG;
    reset_regs.data_seg = `CRRG_RST_ZERO_WORD;
    reset_regs.extra_seg = `CRRG_RST_ZERO_WORD;
    reset_regs.stack_seg = `CRRG_RST_ZERO_WORD;
    reset_regs.relocation = `CRRG_RST_RELOCATION;
    reset_regs.upper_memory_select_ctl = `CRRG_RST_UPPER_MEM_SEL;
  endfunction

  // pclk high: next edge is mid-state; pclk low: next edge ends the state
  assign mid_en = st_r.pclk;
  assign end_en = ~st_r.pclk;
  assign sample_state = in_sample_state(st_r.bus_state);
  assign cycle_start = (st_r.bus_state == crrg_pkg::first_bus_state);

  crrg_ready_sync crrg_ready_sync_i (
    .clock(clock),
    .reset_n(reset_n),
    .mid_en(mid_en),
    .end_en(end_en),
    .sample_state(sample_state),
    .cycle_start(cycle_start),
    .async_ready_in(async_ready_in),
    .sync_ready_in(sync_ready_in),
    .ready_ok(ready_ok)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.cycle_done = 1'b0;

    // divide by two: one toggle per oscillator rising edge
    st_nxt.pclk = ~st_r.pclk;

    // reset synchroniser and stretch, stepped on rising pclk
    if (end_en) begin
      st_nxt.rst_s1 = initialise_in_low;
      st_nxt.rst_s2 = st_r.rst_s1;
      if (!st_r.rst_s2) begin
        st_nxt.reset_out = 1'b1;
        if (st_r.reset_out) begin
          st_nxt.rst_cnt = sat_inc(st_r.rst_cnt, `CRRG_RST_MIN_PCLK);
        end else begin
          st_nxt.rst_cnt = `CRRG_CNT_ONE;
        end
      end else if (st_r.reset_out) begin
        // released early: hold until the minimum width is reached
        if (st_r.rst_cnt >= `CRRG_RST_MIN_PCLK) begin
          st_nxt.reset_out = 1'b0;
        end else begin
          st_nxt.rst_cnt = sat_inc(st_r.rst_cnt, `CRRG_RST_MIN_PCLK);
        end
      end
    end

    if (st_r.reset_out) begin
      // abort everything and load the initial register image
      st_nxt.init_regs = reset_regs();
      st_nxt.bus_state = crrg_pkg::idle_state;
      st_nxt.core_run = 1'b0;
      st_nxt.init_cnt = `CRRG_CNT_ZERO;
      st_nxt.first_fetch = 1'b1;
      st_nxt.wait_count = `CRRG_WAIT_ZERO;
    end else if (end_en) begin
      // internal interval before the core may run
      if (!st_r.core_run) begin
        if (st_r.init_cnt >= `CRRG_INIT_INTERVAL_PCLK) begin
          st_nxt.core_run = 1'b1;
        end else begin
          st_nxt.init_cnt = sat_inc(st_r.init_cnt, `CRRG_INIT_INTERVAL_PCLK);
        end
      end

      unique case (st_r.bus_state)
        crrg_pkg::idle_state: begin
          if (st_r.core_run && bus_request) begin
            st_nxt.bus_state = crrg_pkg::first_bus_state;
            st_nxt.wait_count = `CRRG_WAIT_ZERO;
            st_nxt.first_fetch = 1'b0;
            if (st_r.first_fetch) begin
              st_nxt.bus_addr = `CRRG_FIRST_FETCH_ADDR;
            end else begin
              st_nxt.bus_addr = core_addr;
            end
          end
        end
        crrg_pkg::first_bus_state: begin
          st_nxt.bus_state = crrg_pkg::second_bus_state;
        end
        crrg_pkg::second_bus_state: begin
          st_nxt.bus_state = crrg_pkg::third_bus_state;
        end
        crrg_pkg::third_bus_state: begin
          if (ready_ok) begin
            st_nxt.bus_state = crrg_pkg::last_bus_state;
          end else begin
            st_nxt.bus_state = crrg_pkg::wait_state;
            st_nxt.wait_count = `CRRG_WAIT_ZERO + 4'h1;
          end
        end
        crrg_pkg::wait_state: begin
          if (ready_ok) begin
            st_nxt.bus_state = crrg_pkg::last_bus_state;
          end else if (st_r.wait_count != `CRRG_WAIT_MAX) begin
            st_nxt.wait_count = 4'(st_r.wait_count + 4'h1);
          end
        end
        crrg_pkg::last_bus_state: begin
          st_nxt.bus_state = crrg_pkg::idle_state;
          st_nxt.cycle_done = 1'b1;
        end
        default: begin
          st_nxt.bus_state = crrg_pkg::idle_state;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r.pclk <= 1'b0;
      st_r.rst_s1 <= 1'b0;
      st_r.rst_s2 <= 1'b0;
      st_r.reset_out <= 1'b1;
      st_r.rst_cnt <= `CRRG_CNT_ZERO;
      st_r.init_cnt <= `CRRG_CNT_ZERO;
      st_r.core_run <= 1'b0;
      st_r.first_fetch <= 1'b1;
      st_r.bus_state <= crrg_pkg::idle_state;
      st_r.bus_addr <= `CRRG_FIRST_FETCH_ADDR;
      st_r.cycle_done <= 1'b0;
      st_r.wait_count <= `CRRG_WAIT_ZERO;
      st_r.init_regs.status_word <= `CRRG_RST_STATUS_WORD;
      st_r.init_regs.instr_ptr <= `CRRG_RST_ZERO_WORD;
      st_r.init_regs.code_seg <= `CRRG_RST_CODE_SEG;
      st_r.init_regs.data_seg <= `CRRG_RST_ZERO_WORD;
      st_r.init_regs.extra_seg <= `CRRG_RST_ZERO_WORD;
      st_r.init_regs.stack_seg <= `CRRG_RST_ZERO_WORD;
      st_r.init_regs.relocation <= `CRRG_RST_RELOCATION;
      st_r.init_regs.upper_memory_select_ctl <= `CRRG_RST_UPPER_MEM_SEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the state register
  assign processor_clock_out = st_r.pclk;
  assign reset_out = st_r.reset_out;
  assign core_run = st_r.core_run;
  assign init_regs = st_r.init_regs;
  assign bus_state = st_r.bus_state;
  assign bus_addr = st_r.bus_addr;
  assign bus_cycle_done = st_r.cycle_done;
  assign wait_count = st_r.wait_count;
endmodule
`default_nettype wire

// file: design/crrg_params.svh
// constants of the clock, ready and reset front end
`ifndef CRRG_PARAMS_SVH
`define CRRG_PARAMS_SVH

`define CRRG_FIRST_FETCH_ADDR 20'hffff0
`define CRRG_RST_STATUS_WORD 16'hf002
`define CRRG_RST_CODE_SEG 16'hffff
`define CRRG_RST_ZERO_WORD 16'h0000
`define CRRG_RST_RELOCATION 16'h20ff
`define CRRG_RST_UPPER_MEM_SEL 16'hfffb
`define CRRG_RST_MIN_PCLK 3'h5
`define CRRG_INIT_INTERVAL_PCLK 3'h6
`define CRRG_CNT_ZERO 3'h0
`define CRRG_CNT_ONE 3'h1
`define CRRG_WAIT_MAX 4'hf
`define CRRG_WAIT_ZERO 4'h0

`endif

// file: design/crrg_pkg.sv
// types of the clock, ready and reset front end
`default_nettype none
package crrg_pkg;

  typedef enum logic [2:0] {
    idle_state = 3'h0,
    first_bus_state = 3'h1,
    second_bus_state = 3'h3,
    third_bus_state = 3'h2,
    last_bus_state = 3'h6,
    wait_state = 3'h7
  } crrg_bus_state_t;

  typedef struct packed {
    logic [15:0] status_word;
    logic [15:0] instr_ptr;
    logic [15:0] code_seg;
    logic [15:0] data_seg;
    logic [15:0] extra_seg;
    logic [15:0] stack_seg;
    logic [15:0] relocation;
    logic [15:0] upper_memory_select_ctl;
  } crrg_init_regs_t;

  typedef struct packed {
    logic async_sample;
    logic ready_held;
  } crrg_ready_state_t;

  typedef struct packed {
    logic pclk;
    logic rst_s1;
    logic rst_s2;
    logic reset_out;
    logic [2:0] rst_cnt;
    logic [2:0] init_cnt;
    logic core_run;
    logic first_fetch;
    crrg_bus_state_t bus_state;
    logic [19:0] bus_addr;
    logic cycle_done;
    logic [3:0] wait_count;
    crrg_init_regs_t init_regs;
  } crrg_top_state_t;

endpackage
`default_nettype wire

// file: design/crrg_ready_sync.sv
// ready sampling for the bus state sequence
`timescale 1ns/1ps
`default_nettype none
module crrg_ready_sync (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // phase enables and bus state qualifiers
  input wire logic mid_en,
  input wire logic end_en,
  input wire logic sample_state,
  input wire logic cycle_start,
  // ready pins
  input wire logic async_ready_in,
  input wire logic sync_ready_in,
  // ready seen at the end of the current state
  output logic ready_ok
);
  crrg_pkg::crrg_ready_state_t st_r;
  crrg_pkg::crrg_ready_state_t st_nxt;
  logic seen_now;

  always_comb begin
    st_nxt = st_r;
    // async sample at the middle of the state, resolved by its end
    seen_now = end_en & sample_state & (st_r.async_sample | sync_ready_in);
    if (mid_en && sample_state) begin
      st_nxt.async_sample = async_ready_in;
    end
    if (cycle_start) begin
      st_nxt.ready_held = 1'b0;
      st_nxt.async_sample = 1'b0;
    end else if (seen_now) begin
      st_nxt.ready_held = 1'b1;
    end
    ready_ok = st_r.ready_held | seen_now;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tb/crrg_checker.sv
// port assertions of the clock, ready and reset front end
`timescale 1ns/1ps
`default_nettype none
module crrg_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // pins and core side
  input wire logic initialise_in_low,
  input wire logic async_ready_in,
  input wire logic sync_ready_in,
  input wire logic bus_request,
  input wire logic [19:0] core_addr,
  input wire logic processor_clock_out,
  input wire logic reset_out,
  input wire logic core_run,
  input var crrg_pkg::crrg_init_regs_t init_regs,
  input var crrg_pkg::crrg_bus_state_t bus_state,
  input wire logic [19:0] bus_addr,
  input wire logic bus_cycle_done,
  input wire logic [3:0] wait_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // clocks spent with reset out high
  logic [4:0] high_cnt_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_cnt_r <= 5'h0;
    end else if (!reset_out) begin
      high_cnt_r <= 5'h0;
    end else if (high_cnt_r != 5'h1f) begin
      high_cnt_r <= high_cnt_r + 5'h1;
    end
  end
  property p_half; 1'b1 |=> processor_clock_out != $past(processor_clock_out); endproperty
  a_half: assert property (p_half) else $error("clock out not halved");
  property p_abort; reset_out |=> bus_state == crrg_pkg::idle_state; endproperty
  a_abort: assert property (p_abort) else $error("bus active in reset");
  property p_hold; reset_out |=> !core_run; endproperty
  a_hold: assert property (p_hold) else $error("core runs in reset");
  property p_regs; reset_out |-> init_regs == {16'hf002, 16'h0000, 16'hffff, 16'h0000,
    16'h0000, 16'h0000, 16'h20ff, 16'hfffb}; endproperty
  a_regs: assert property (p_regs) else $error("initial values wrong");
  property p_enter_wait; $changed(wait_count) && wait_count != 4'h0 |->
    !$past(sync_ready_in) && !$past(async_ready_in, 2); endproperty
  a_enter_wait: assert property (p_enter_wait) else $error("wait despite ready");
  property p_sync_end; bus_state == crrg_pkg::wait_state && !processor_clock_out &&
    sync_ready_in && !reset_out |=> bus_state == crrg_pkg::last_bus_state; endproperty
  a_sync_end: assert property (p_sync_end) else $error("sync ready ignored");
  property p_async_end; bus_state == crrg_pkg::wait_state && processor_clock_out &&
    async_ready_in && !reset_out |=> bus_state == crrg_pkg::wait_state ##1
    bus_state == crrg_pkg::last_bus_state; endproperty
  a_async_end: assert property (p_async_end) else $error("async ready timing");
  property p_done; bus_cycle_done |-> $past(bus_state) == crrg_pkg::last_bus_state; endproperty
  a_done: assert property (p_done) else $error("done without last state");
  property p_lag; $fell(initialise_in_low) |-> ##[0:6] reset_out; endproperty
  a_lag: assert property (p_lag) else $error("reset out too late");
  property p_min; $fell(reset_out) |-> high_cnt_r >= 5'ha; endproperty
  a_min: assert property (p_min) else $error("reset out too short");
  property p_run; $fell(reset_out) |-> (!core_run) [*8] ##[1:12] core_run; endproperty
  a_run: assert property (p_run) else $error("run interval wrong");
  c_wait: cover property (bus_state == crrg_pkg::wait_state ##2 bus_cycle_done == 1'b0);
  c_done: cover property (bus_cycle_done);
  c_rst: cover property ($fell(reset_out));
endmodule
bind crrg_top crrg_checker crrg_checker_i (.clock(clock), .reset_n(reset_n),
  .initialise_in_low(initialise_in_low), .async_ready_in(async_ready_in),
  .sync_ready_in(sync_ready_in), .bus_request(bus_request), .core_addr(core_addr),
  .processor_clock_out(processor_clock_out), .reset_out(reset_out), .core_run(core_run),
  .init_regs(init_regs), .bus_state(bus_state), .bus_addr(bus_addr),
  .bus_cycle_done(bus_cycle_done), .wait_count(wait_count));
`default_nettype wire

// file: tb/crrg_ready_model.sv
// external ready logic of a slow memory
`timescale 1ns/1ps
`default_nettype none
module crrg_ready_model (
  // clock and observed bus
  input wire logic clock,
  input var crrg_pkg::crrg_bus_state_t bus_state,
  input wire logic [3:0] wait_count,
  // wait states wanted and pin choice
  input wire logic [3:0] waits,
  input wire logic use_async,
  // ready pins
  output logic async_ready_in,
  output logic sync_ready_in
);
  logic ready;
  assign ready = (bus_state == crrg_pkg::second_bus_state || bus_state ==
    crrg_pkg::third_bus_state || bus_state == crrg_pkg::wait_state) && wait_count >= waits;
  initial begin
    async_ready_in = 1'b0;
    sync_ready_in = 1'b0;
  end
  // moves only on the falling edge of the oscillator clock
  always @(negedge clock) begin
    async_ready_in <= use_async && ready;
    sync_ready_in <= !use_async && ready;
  end
endmodule
`default_nettype wire

// file: tb/clock_ready_reset_gen_tb.sv
// testbench of the clock, ready and reset front end
`timescale 1ns/1ps
`default_nettype none
module clock_ready_reset_gen_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic initialise_in_low = 1'b0;
  logic bus_request = 1'b0;
  logic [19:0] core_addr = 20'hffff0;
  logic [3:0] waits = 4'h0;
  logic use_async = 1'b0;
  logic async_ready_in, sync_ready_in, processor_clock_out, reset_out, core_run, bus_cycle_done;
  logic [19:0] bus_addr;
  logic [3:0] wait_count;
  crrg_pkg::crrg_init_regs_t init_regs;
  crrg_pkg::crrg_bus_state_t bus_state;
  logic [3:0] wlist [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  crrg_top crrg_top_i (.clock(clock), .reset_n(reset_n), .initialise_in_low(initialise_in_low),
    .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in), .bus_request(bus_request),
    .core_addr(core_addr), .processor_clock_out(processor_clock_out), .reset_out(reset_out),
    .core_run(core_run), .init_regs(init_regs), .bus_state(bus_state), .bus_addr(bus_addr),
    .bus_cycle_done(bus_cycle_done), .wait_count(wait_count));
  crrg_ready_model crrg_ready_model_i (.clock(clock), .bus_state(bus_state),
    .wait_count(wait_count), .waits(waits), .use_async(use_async),
    .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in));
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // pin released, reset out must follow and core must start
  task automatic release_pin;
    int t;
    bus_request = 1'b0;
    initialise_in_low = 1'b1;
    check("reset held", reset_out, 1'b1);
    t = 0;
    while (reset_out !== 1'b0 && t < 30) begin
      @(negedge clock);
      t++;
    end
    check("reset lag", t <= 6, 1'b1);
    t = 0;
    while (core_run !== 1'b1 && t < 40) begin
      @(negedge clock);
      t++;
    end
    check("run", core_run, 1'b1);
  endtask
  task automatic power_up;
    logic p;
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    bus_request = 1'b1;
    repeat (12) @(negedge clock);
    check("no run", core_run, 1'b0);
    check("idle", bus_state, crrg_pkg::idle_state);
    check("regs", init_regs, {16'hf002, 16'h0000, 16'hffff, 48'h0, 16'h20ff, 16'hfffb});
    for (int i = 0; i < 4; i++) begin
      p = processor_clock_out;
      @(negedge clock);
      check("clock out", processor_clock_out, !p);
    end
    release_pin();
  endtask
  task automatic run_cycle(input logic [19:0] addr, input logic [3:0] n, input logic asy,
    input logic [19:0] exp_addr);
    int t;
    logic [3:0] w;
    @(negedge clock);
    core_addr = addr;
    waits = n;
    use_async = asy;
    bus_request = 1'b1;
    t = 0;
    while (bus_state !== crrg_pkg::first_bus_state && t < 8) begin
      @(negedge clock);
      t++;
    end
    bus_request = 1'b0;
    check("addr", bus_addr, exp_addr);
    t = 0;
    w = 4'h0;
    while (bus_cycle_done !== 1'b1 && t < 80) begin
      @(negedge clock);
      t++;
      if (bus_state === crrg_pkg::last_bus_state) begin
        w = wait_count;
      end
    end
    check("length", t, 8 + 2 * n);
    check("waits", w, n);
  endtask
  // pin reset in the middle of a waiting cycle
  task automatic abort_cycle;
    @(negedge clock);
    waits = 4'hf;
    use_async = 1'b1;
    bus_request = 1'b1;
    repeat (12) @(negedge clock);
    check("in wait", bus_state, crrg_pkg::wait_state);
    initialise_in_low = 1'b0;
    repeat (12) @(negedge clock);
    check("aborted", bus_state, crrg_pkg::idle_state);
    check("no run", core_run, 1'b0);
    release_pin();
  endtask
  initial begin
    power_up();
    run_cycle(20'h12345, 4'h0, 1'b0, 20'hffff0);
    for (int i = 0; i < 8; i++) begin
      run_cycle(20'h10000 + 20'(i), wlist[i % 4], i >= 4, 20'h10000 + 20'(i));
    end
    abort_cycle();
    run_cycle(20'h2abcd, 4'h1, 1'b1, 20'hffff0);
    give_verdict();
  end
endmodule
`default_nettype wire
